/* File: src/cab_defs.vh */
// Constants for the ALU and branch subset execution block
`ifndef CAB_DEFS_VH
`define CAB_DEFS_VH

// ---------------------------------------------------------------
// Opcode patterns
// ---------------------------------------------------------------
`define CAB_OP_ADDC_HI   6'h08
`define CAB_OP_ANDF_HI   6'h05
`define CAB_OP_ANDL_HI   8'h0B
`define CAB_OP_BRC_HI    8'hE2
`define CAB_OP_BRN_HI    8'hE6
`define CAB_OP_BCLR_HI   4'h9

// ---------------------------------------------------------------
// Instruction field positions and access address limits
// ---------------------------------------------------------------
`define CAB_BIT_DEST     9
`define CAB_BIT_ACCESS   8
`define CAB_IDX_LIMIT    8'h5F
`define CAB_ACC_SPLIT    8'h60

// ---------------------------------------------------------------
// Status flag positions and reset values
// ---------------------------------------------------------------
`define CAB_FLG_C        0
`define CAB_FLG_DIGIT    1
`define CAB_FLG_Z        2
`define CAB_FLG_OVF      3
`define CAB_FLG_N        4
`define CAB_RST_STATUS   5'h00
`define CAB_RST_ACC      8'h00
`define CAB_RST_PC       21'h000000

// ---------------------------------------------------------------
// Phase timing and access bank upper address bits
// ---------------------------------------------------------------
`define CAB_PHASES       4
`define CAB_BANK_ACCESS_HI 4'hF

`endif

/* File: src/cab_alu.v */
// Arithmetic and logic unit for the execution subset
`timescale 1ns/10ps
module cab_alu (
  // Operands
  input  wire [7:0] i_acc,
  input  wire [7:0] i_opnd,
  input  wire       i_carry,
  // Operation select: 0 add with carry, 1 and, 2 bit clear
  input  wire [1:0] i_sel,
  input  wire [2:0] i_bit,
  // Results
  output reg  [7:0] o_res,
  output reg        o_c,
  output reg        o_digit,
  output reg        o_ovf
);
  reg [8:0] sum;
  reg [4:0] low;

  // Full adder paths plus logic ops
  always @* begin
    sum  = {1'b0, i_acc} + {1'b0, i_opnd} + {8'h00, i_carry};
    low  = {1'b0, i_acc[3:0]} + {1'b0, i_opnd[3:0]} + {4'h0, i_carry};
    o_c  = sum[8];
    o_digit = low[4];
    // Signed overflow: like-signed operands giving an unlike-signed result
    o_ovf = (i_acc[7] == i_opnd[7]) && (sum[7] != i_acc[7]);
    case (i_sel)
      2'h0:    o_res = sum[7:0];
      2'h1:    o_res = i_acc & i_opnd;
      2'h2:    o_res = i_opnd & ~(8'h01 << i_bit);
      default: o_res = 8'h00;
    endcase
  end
endmodule

/* File: src/cab_core.v */
// Execution block for add-with-carry, AND, bit clear and carry/negative branches
// Behaviour
// RQ1 - Add-with-carry sums acc, file and carry; updates negative, overflow, carry, digit carry, zero.
// RQ2 - Destination bit 0 writes accumulator; 1 writes back to the file register.
// RQ3 - Access bit 0 uses access bank; 1 uses bank select for upper bits.
// RQ4 - Extended set, access 0, address up to 5Fh becomes indexed literal offset.
// RQ5 - AND-literal ANDs immediate into accumulator; updates only N and Z.
// RQ6 - AND-file ANDs acc with file, routed by destination; updates N and Z.
// RQ7 - Branch on carry set uses signed 8-bit offset, touches no flags.
// RQ8 - Branch on negative set uses signed 8-bit offset, touches no flags.
// RQ9 - Taken branch loads incremented counter plus twice the sign-extended offset.
// RQ10 - Branch takes one cycle untaken, two taken with an idle second cycle.
// RQ11 - Bit clear reads file, clears selected bit, writes back, no flags.
// RQ12 - Each ALU or bit instruction completes within one four-phase cycle.
`timescale 1ns/10ps
`include "cab_defs.vh"
module cab_core (
  // Clock and reset
  input  wire        i_core_clk,
  input  wire        i_rst_n,
  input  wire        i_clk_en,
  // Instruction stream, one word per instruction cycle
  input  wire        i_instr_valid,
  input  wire [15:0] i_instr,
  input  wire        i_ext_set_en,
  input  wire [3:0]  i_bank_select_reg,
  input  wire [11:0] i_fsr2,
  // Data memory read and write port
  input  wire [7:0]  i_mem_rdata,
  output reg  [11:0] o_mem_addr,
  output reg         o_mem_rd,
  output reg         o_mem_we,
  output reg  [7:0]  o_mem_wdata,
  // Program counter and core state
  output reg  [20:0] o_pc,
  output reg         o_pc_load,
  output reg  [7:0]  o_acc,
  output reg  [4:0]  o_status,
  output reg  [1:0]  o_phase,
  output reg         o_busy,
  output reg         o_illegal
);

  // ---------------------------------------------------------------
  // Phase sequencing
  // ---------------------------------------------------------------
  localparam PH_DECODE = 2'h0;
  localparam PH_READ   = 2'h1;
  localparam PH_PROC   = 2'h2;
  localparam PH_WRITE  = 2'h3;

  localparam K_NONE = 3'h0;
  localparam K_ADDC = 3'h1;
  localparam K_ANDL = 3'h2;
  localparam K_ANDF = 3'h3;
  localparam K_BCLR = 3'h4;
  localparam K_BRC  = 3'h5;
  localparam K_BRN  = 3'h6;

  reg [1:0]  phase_q;
  reg [2:0]  kind_q;
  reg [15:0] ins_q;
  reg        nop_cyc_q;   // Second, idle cycle of a taken branch
  reg [7:0]  opnd_q;
  reg        take_q;

  reg [1:0]  phase_d;
  reg [2:0]  kind_d;
  reg [11:0] addr_d;
  reg [4:0]  status_d;
  wire [7:0] alu_res;
  wire       alu_c;
  wire       alu_digit;
  wire       alu_ovf;
  reg  [1:0] alu_sel;
  wire       accept;      // Word taken this clock
  wire       uses_file;   // Instruction reads a data-memory operand
  wire       to_file;     // Result goes back to the file register
  wire       is_branch;   // Either conditional branch
  wire       rd_now;      // Read strobe due this clock
  wire       wr_now;      // Write strobe due this clock
  wire       jump_now;    // Counter load due this clock
  wire [20:0] br_off;     // Twice the sign-extended branch offset

  // ---------------------------------------------------------------
  // Opcode decode
  // ---------------------------------------------------------------
  always @* begin
    kind_d = K_NONE;
    if (i_instr[15:10] == `CAB_OP_ADDC_HI)
      kind_d = K_ADDC;                                   // RQ1
    else if (i_instr[15:8] == `CAB_OP_ANDL_HI)
      kind_d = K_ANDL;                                   // RQ5
    else if (i_instr[15:10] == `CAB_OP_ANDF_HI)
      kind_d = K_ANDF;                                   // RQ6
    else if (i_instr[15:12] == `CAB_OP_BCLR_HI)
      kind_d = K_BCLR;                                   // RQ11
    else if (i_instr[15:8] == `CAB_OP_BRC_HI)
      kind_d = K_BRC;                                    // RQ7
    else if (i_instr[15:8] == `CAB_OP_BRN_HI)
      kind_d = K_BRN;                                    // RQ8
  end

  // ---------------------------------------------------------------
  // Data address formation
  // ---------------------------------------------------------------
  // Access bank splits at 60h: low part is bank 0, high part the SFR bank
  always @* begin
    if (ins_q[`CAB_BIT_ACCESS])
      addr_d = {i_bank_select_reg, ins_q[7:0]};          // RQ3
    else if (i_ext_set_en && (ins_q[7:0] <= `CAB_IDX_LIMIT))
      addr_d = i_fsr2 + {4'h0, ins_q[7:0]};              // RQ4
    else if (ins_q[7:0] < `CAB_ACC_SPLIT)
      addr_d = {4'h0, ins_q[7:0]};                       // RQ3
    else
      addr_d = {`CAB_BANK_ACCESS_HI, ins_q[7:0]};        // RQ3
  end

  // ALU operation select from the latched kind
  always @* begin
    case (kind_q)
      K_ADDC:  alu_sel = 2'h0;
      K_BCLR:  alu_sel = 2'h2;
      default: alu_sel = 2'h1;
    endcase
  end

  cab_alu cab_alu_i (
    .i_acc   (o_acc),
    .i_opnd  (opnd_q),
    .i_carry (kind_q == K_ADDC ? o_status[`CAB_FLG_C] : 1'b0),
    .i_sel   (alu_sel),
    .i_bit   (ins_q[11:9]),
    .o_res   (alu_res),
    .o_c     (alu_c),
    .o_digit (alu_digit),
    .o_ovf   (alu_ovf)
  );

  // ---------------------------------------------------------------
  // Shared decode of the latched word
  // ---------------------------------------------------------------
  // A word is taken only in decode and never while a taken branch owes its idle cycle
  assign accept    = (phase_q == PH_DECODE) && !nop_cyc_q && i_instr_valid;
  assign uses_file = (kind_q == K_ADDC) || (kind_q == K_ANDF) || (kind_q == K_BCLR);
  // The literal form has no destination bit: bit 9 there is part of the opcode and must not steer the result
  assign to_file   = (kind_q == K_BCLR) || ((kind_q == K_ADDC || kind_q == K_ANDF) && ins_q[`CAB_BIT_DEST]);
  assign is_branch = (kind_q == K_BRC) || (kind_q == K_BRN);
  assign br_off    = {{12{ins_q[7]}}, ins_q[7:0], 1'b0};                    // RQ9

  // ---------------------------------------------------------------
  // Phase qualifiers
  // ---------------------------------------------------------------
  // Every strobe below is gated by one of these, so nothing moves outside its own phase
  assign rd_now    = (phase_q == PH_READ) && uses_file;
  assign wr_now    = (phase_q == PH_WRITE) && to_file;
  assign jump_now  = (phase_q == PH_WRITE) && is_branch && take_q;

  // ---------------------------------------------------------------
  // Next phase
  // ---------------------------------------------------------------
  // Decode holds while nothing is taken and no idle cycle is owed, so the phase output never runs ahead of the core
  always @* begin
    case (phase_q)
      PH_DECODE: phase_d = (accept || nop_cyc_q) ? PH_READ : PH_DECODE;
      PH_READ:   phase_d = PH_PROC;
      PH_PROC:   phase_d = PH_WRITE;
      PH_WRITE:  phase_d = PH_DECODE;
      default:   phase_d = PH_DECODE;
    endcase
  end

  // ---------------------------------------------------------------
  // Flag update
  // ---------------------------------------------------------------
  // Only the add path touches carry, digit carry and overflow; the AND paths keep them
  // Bit clear and branches never take this value, the flag register ignores it for them
  always @* begin
    status_d                   = o_status;
    status_d[`CAB_FLG_N]       = alu_res[7];                                // RQ5
    status_d[`CAB_FLG_Z]       = (alu_res == 8'h00);                        // RQ6
    if (kind_q == K_ADDC) begin
      status_d[`CAB_FLG_C]     = alu_c;                                     // RQ1
      status_d[`CAB_FLG_DIGIT] = alu_digit;
      status_d[`CAB_FLG_OVF]   = alu_ovf;
    end
  end

  // ---------------------------------------------------------------
  // Instruction sequencer
  // ---------------------------------------------------------------
  // Word, kind and operand are latched phase by phase; a taken branch arms one idle cycle
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_q   <= PH_DECODE;
      kind_q    <= K_NONE;
      ins_q     <= 16'h0000;
      nop_cyc_q <= 1'b0;
      opnd_q    <= 8'h00;
      take_q    <= 1'b0;
    end else if (i_clk_en) begin
      phase_q <= phase_d;
      case (phase_q)
        PH_DECODE: begin
          if (nop_cyc_q) begin
            kind_q <= K_NONE;                                               // RQ10
          end else if (accept) begin
            ins_q  <= i_instr;
            kind_q <= kind_d;
          end
        end
        PH_PROC: begin
          // Memory answers the read within the clock after the strobe
          opnd_q <= (kind_q == K_ANDL) ? ins_q[7:0] : i_mem_rdata;
          take_q <= (kind_q == K_BRC && o_status[`CAB_FLG_C]) ||            // RQ7
                    (kind_q == K_BRN && o_status[`CAB_FLG_N]);              // RQ8
        end
        PH_WRITE: begin
          nop_cyc_q <= is_branch && take_q;                                 // RQ10
        end
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Data memory strobes
  // ---------------------------------------------------------------
  // Address is held after the read so the write lands on the same location
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mem_addr  <= 12'h000;
      o_mem_rd    <= 1'b0;
      o_mem_we    <= 1'b0;
      o_mem_wdata <= 8'h00;
    end else if (i_clk_en) begin
      o_mem_rd <= rd_now;
      o_mem_we <= wr_now;                                                   // RQ2 RQ11
      if (rd_now)
        o_mem_addr <= addr_d;                                               // RQ3
      if (wr_now)
        o_mem_wdata <= alu_res;                                             // RQ11
    end
  end

  // ---------------------------------------------------------------
  // Program counter
  // ---------------------------------------------------------------
  // The counter already points past the word when the doubled offset is added
  // Untaken branches only step past themselves, within one cycle
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pc      <= `CAB_RST_PC;
      o_pc_load <= 1'b0;
    end else if (i_clk_en) begin
      o_pc_load <= jump_now;
      if (accept)
        o_pc <= o_pc + 21'h000002;
      else if (jump_now)
        o_pc <= o_pc + br_off;                                              // RQ9
    end
  end

  // ---------------------------------------------------------------
  // Working register and flags
  // ---------------------------------------------------------------
  // Branches and bit clear leave both alone; a file destination spares the accumulator
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_acc    <= `CAB_RST_ACC;
      o_status <= `CAB_RST_STATUS;
    end else if (i_clk_en && (phase_q == PH_WRITE)) begin
      if (kind_q == K_ADDC || kind_q == K_ANDL || kind_q == K_ANDF) begin
        o_status <= status_d;                                               // RQ1 RQ5 RQ6
        if (!to_file)
          o_acc <= alu_res;                                                 // RQ2
      end
    end
  end

  // ---------------------------------------------------------------
  // Core state outputs
  // ---------------------------------------------------------------
  // Busy covers the idle cycle of a taken branch too, since no word is taken then
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_phase   <= PH_DECODE;
      o_busy    <= 1'b0;
      o_illegal <= 1'b0;
    end else if (i_clk_en) begin
      o_phase <= phase_d;
      if (phase_q == PH_DECODE) begin
        o_busy    <= accept || nop_cyc_q;
        o_illegal <= accept && (kind_d == K_NONE);                          // RQ12
      end else if (phase_q == PH_WRITE) begin
        o_busy    <= 1'b0;                                                  // RQ12
      end
    end
  end
endmodule

/* File: testbench/cab_mem_model.sv */
// Banked data memory model facing the execution block
`timescale 1ns/10ps
module cab_mem_model (
  // Memory port of the core
  input  wire       i_clk,
  input  wire       i_rd,
  input  wire       i_we,
  input  wire [11:0] i_addr,
  input  wire [7:0] i_wdata,
  output wire [7:0] o_rdata
);
  reg [7:0] mem [0:4095];
  reg       rd_q = 1'b0;
  reg [7:0] last_q = 8'h00;
  // Data holds for the read cycle and the one after, then goes stale so a late sample shows
  always @(posedge i_clk) begin
    rd_q <= i_rd;
    if (i_we)
      mem[i_addr] <= i_wdata;
    if (i_rd | rd_q)
      last_q <= mem[i_addr];
  end
  assign o_rdata = (i_rd | rd_q) ? mem[i_addr] : ~last_q;
endmodule

/* File: testbench/cab_core_chk.sv */
// Timing and side-effect checks on the execution block ports
`timescale 1ns/10ps
module cab_core_chk (
  input wire        i_core_clk,
  input wire        i_rst_n,
  input wire        o_mem_rd,
  input wire        o_mem_we,
  input wire [11:0] o_mem_addr,
  input wire        o_pc_load,
  input wire [7:0]  o_acc,
  input wire [4:0]  o_status,
  input wire        o_illegal
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // Clock enable is held high by the bench, so cycle spacing is exact
  rd_once_a: assert property (o_mem_rd |=> !o_mem_rd [*3]) else $error("read strobe repeated");
  we_once_a: assert property (o_mem_we |=> !o_mem_we [*3]) else $error("write strobe repeated");
  we_after_rd_a: assert property (o_mem_we |-> $past(o_mem_rd, 2)) else $error("write not two after read");
  we_same_addr_a: assert property (o_mem_we |-> o_mem_addr == $past(o_mem_addr, 2)) else $error("write moved");
  we_keeps_acc_a: assert property (o_mem_we |-> o_acc == $past(o_acc)) else $error("acc changed on write");
  branch_flags_a: assert property (o_pc_load |-> o_status == $past(o_status)) else $error("branch changed flags");
  branch_idle_a: assert property (o_pc_load |=> (!o_mem_rd && !o_mem_we && !o_pc_load) [*4])
    else $error("activity in branch idle cycle");
  load_no_we_a: assert property (o_pc_load |-> !o_mem_we) else $error("branch wrote memory");
  illegal_quiet_a: assert property (o_illegal |-> !o_mem_we && !o_pc_load) else $error("unknown op acted");
endmodule
bind cab_core cab_core_chk cab_core_chk_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .o_mem_rd(o_mem_rd),
  .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr), .o_pc_load(o_pc_load), .o_acc(o_acc), .o_status(o_status),
  .o_illegal(o_illegal));

/* File: testbench/cpu_alu_and_branch_subset_tb.sv */
// Self-checking bench for the ALU and branch subset
`timescale 1ns/10ps
`include "cab_defs.vh"
module cpu_alu_and_branch_subset_tb;
  reg         clk, rst_n, vld, ext;
  reg  [15:0] ins;
  reg  [3:0]  bank;
  reg  [11:0] fsr;
  reg  [20:0] pc_e;
  wire [7:0]  rdat, acc, wdat;
  wire [11:0] addr;
  wire [20:0] pc;
  wire [4:0]  st;
  wire [1:0]  ph;
  wire        rd, we, pcl, ill, bsy;
  integer     fails = 0, n_tests = 0, cyc = 0;
  cab_core cab_core_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_clk_en(1'b1), .i_instr_valid(vld), .i_instr(ins),
    .i_ext_set_en(ext), .i_bank_select_reg(bank), .i_fsr2(fsr), .i_mem_rdata(rdat), .o_mem_addr(addr),
    .o_mem_rd(rd), .o_mem_we(we), .o_mem_wdata(wdat), .o_pc(pc), .o_pc_load(pcl), .o_acc(acc),
    .o_status(st), .o_phase(ph), .o_busy(bsy), .o_illegal(ill));
  cab_mem_model cab_mem_model_i (.i_clk(clk), .i_rd(rd), .i_we(we), .i_addr(addr), .i_wdata(wdat),
    .o_rdata(rdat));
  // ----------------------------------------
  // Shared checks and instruction driver
  // ----------------------------------------
  task stop_test;
    begin
      if (fails == 0 && n_tests > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input [20:0] g, input [20:0] e);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  // Memory writes land on the edge after the write strobe, so look one clock later
  task chkm(input [11:0] a, input [7:0] e);
    begin
      @(negedge clk);
      chk(cab_mem_model_i.mem[a], e);
    end
  endtask
  // Issue one word at a phase-0 boundary, check results after four clocks
  task ex(input [15:0] w, input [7:0] ea, input [4:0] es, input [3:0] idle);
    begin
      while (ph !== 2'h0) @(negedge clk);
      ins = w;
      vld = 1'b1;
      pc_e = pc_e + 21'h2;
      @(negedge clk);
      vld = 1'b0;
      chk(ill, w == 16'hFFFF);
      chk(bsy, 21'h1);
      repeat (3) @(negedge clk);
      chk(acc, ea);
      chk(st, es);
      chk(pc, pc_e);
      chk(bsy, 21'h0);
      repeat (idle) @(negedge clk);
    end
  endtask
  // Taken branch: target plus twice the signed offset, then a four-clock idle cycle
  task br(input [15:8] op, input [7:0] n, input [7:0] ea, input [4:0] es);
    begin
      pc_e = pc_e + {{12{n[7]}}, n, 1'b0};
      ex({op, n}, ea, es, 4'h4);
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task sc_addc;
    begin
      cab_mem_model_i.mem[12'h010] = 8'hC3;
      ex({`CAB_OP_ADDC_HI, 2'b00, 8'h10}, 8'hC3, 5'h10, 4'h0);
      br(`CAB_OP_BRN_HI, 8'hFE, 8'hC3, 5'h10);
      bank = 4'h3;
      cab_mem_model_i.mem[12'h320] = 8'hFF;
      ex({`CAB_OP_ADDC_HI, 2'b01, 8'h20}, 8'hC2, 5'h13, 4'h0);
    end
  endtask
  task sc_andl_branch;
    begin
      ex({`CAB_OP_ANDL_HI, 8'h0F}, 8'h02, 5'h03, 4'h0);
      br(`CAB_OP_BRC_HI, 8'h05, 8'h02, 5'h03);
      br(`CAB_OP_BRC_HI, 8'h80, 8'h02, 5'h03);
      ex({`CAB_OP_BRN_HI, 8'h7F}, 8'h02, 5'h03, 4'h0);
    end
  endtask
  task sc_dest_and;
    begin
      cab_mem_model_i.mem[12'hF70] = 8'h4D;
      ex({`CAB_OP_ADDC_HI, 2'b10, 8'h70}, 8'h02, 5'h02, 4'h0);
      chkm(12'hF70, 8'h50);
      cab_mem_model_i.mem[12'h030] = 8'hF0;
      ex({`CAB_OP_ANDF_HI, 2'b10, 8'h30}, 8'h02, 5'h06, 4'h0);
      chkm(12'h030, 8'h00);
      cab_mem_model_i.mem[12'h331] = 8'hFE;
      ex({`CAB_OP_ANDF_HI, 2'b01, 8'h31}, 8'h02, 5'h02, 4'h0);
    end
  endtask
  task sc_ext;
    begin
      ext = 1'b1;
      fsr = 12'h100;
      cab_mem_model_i.mem[12'h105] = 8'h7F;
      cab_mem_model_i.mem[12'hF60] = 8'h01;
      ex({`CAB_OP_ADDC_HI, 2'b00, 8'h05}, 8'h81, 5'h1A, 4'h0);
      ex({`CAB_OP_ADDC_HI, 2'b00, 8'h60}, 8'h82, 5'h10, 4'h0);
      ext = 1'b0;
    end
  endtask
  task sc_bclr_ill;
    begin
      cab_mem_model_i.mem[12'h040] = 8'hC7;
      ex({`CAB_OP_BCLR_HI, 3'h7, 1'b0, 8'h40}, 8'h82, 5'h10, 4'h0);
      chkm(12'h040, 8'h47);
      bank = 4'h1;
      cab_mem_model_i.mem[12'h1C1] = 8'hFF;
      ex({`CAB_OP_BCLR_HI, 3'h0, 1'b1, 8'hC1}, 8'h82, 5'h10, 4'h0);
      chkm(12'h1C1, 8'hFE);
      ex(16'hFFFF, 8'h82, 5'h10, 4'h0);
    end
  endtask
  // ----------------------------------------
  // Clock, reset, sequence and hang guard
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Ceiling is some 25 times the expected run of about 78 clocks
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      fails = fails + 1;
      stop_test;
    end
  end
  initial begin
    rst_n = 1'b0;
    vld = 1'b0;
    ext = 1'b0;
    ins = 16'h0000;
    bank = 4'h0;
    fsr = 12'h000;
    pc_e = 21'h0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    sc_addc;
    sc_andl_branch;
    sc_dest_and;
    sc_ext;
    sc_bclr_ill;
    stop_test;
  end
endmodule
